// ---- verilog/esc_pkg.sv ----
// Constants shared by both ends of the encoder control port.
// Assumes one clock, core_clk, which is the double-rate clock.
// Function
// [RL1] Field id in bits 7-5, 12 clocks after sync
// [RL2] Line kind in bits 4-0, 5 clocks after sync
// [RL3] Four byte registers form 32-bit subcarrier step
// [RL4] Active video phase offset from two bytes
// [RL5] Burst phase offset from two bytes
// [RL6] Test port byte by lane, no pointer increment
// [RL7] Host leaves test by writing pointer, lines low
// [RL8] Colour index pixels ANDed with mask
// [RL9] Mask is write only, no read-back
// [RL10] Pointer 60h reads the pre-sync luma value
// [RL11] Entry loaded as three bytes, tables in order
// [RL12] Table address advances after three bytes
// [RL13] Index drives three tables, red green blue
// [RL14] Six-bit host data MSB-justified, low bits zero
// [RL15] Unity load: entry equals its address
// [RL16] GBR loads green blue red; RGB red green blue
// [RL17] Colour difference loads luma, blue, red difference
// [RL18] Pixel clock is two double-rate clock periods
// [RL19] New table address restarts byte sequence
package esc_pkg;
	// ------------------------------------------------------------
	// Link address lines
	// ------------------------------------------------------------
	localparam logic [1:0] ESC_A_PTR = 2'h0; // Register pointer
	localparam logic [1:0] ESC_A_REG = 2'h1; // Pointed register data
	localparam logic [1:0] ESC_A_LADDR = 2'h2; // Table address
	localparam logic [1:0] ESC_A_LDATA = 2'h3; // Table data
	// ------------------------------------------------------------
	// Device register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ESC_R_IDENT = 8'h1F;
	localparam logic [7:0] ESC_R_STEP0 = 8'h20;
	localparam logic [7:0] ESC_R_STEP1 = 8'h21;
	localparam logic [7:0] ESC_R_STEP2 = 8'h22;
	localparam logic [7:0] ESC_R_STEP3 = 8'h23;
	localparam logic [7:0] ESC_R_APH_LO = 8'h24;
	localparam logic [7:0] ESC_R_APH_HI = 8'h25;
	localparam logic [7:0] ESC_R_BPH_LO = 8'h26;
	localparam logic [7:0] ESC_R_BPH_HI = 8'h27;
	localparam logic [7:0] ESC_R_TEST = 8'h40;
	localparam logic [7:0] ESC_R_MASK = 8'h50;
	localparam logic [7:0] ESC_R_LUMA = 8'h60;
	// ------------------------------------------------------------
	// Timing, counted in double-rate clocks, and table depth
	// ------------------------------------------------------------
	localparam logic [3:0] ESC_KIND_DLY = 4'h5;
	localparam logic [3:0] ESC_FIELD_DLY = 4'hC;
	localparam int ESC_LUT_DEPTH = 256;
	// ------------------------------------------------------------
	// Host command register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] ESC_H_LINES = 4'h0; // Lines for single access
	localparam logic [3:0] ESC_H_WRITE = 4'h1; // Start single write
	localparam logic [3:0] ESC_H_READ = 4'h2; // Start read; read: last byte
	localparam logic [3:0] ESC_H_STAT = 4'h3; // Bit 0 busy
	localparam logic [3:0] ESC_H_LCFG = 4'h4; // Order, six-bit, unity
	localparam logic [3:0] ESC_H_COMP0 = 4'h5; // Red or luma
	localparam logic [3:0] ESC_H_COMP1 = 4'h6; // Green or blue difference
	localparam logic [3:0] ESC_H_COMP2 = 4'h7; // Blue or red difference
	localparam logic [3:0] ESC_H_LGO = 4'h8; // Table address, starts load
	localparam logic [3:0] ESC_H_EXIT = 4'h9; // Reset device pointer
	// Load orders
	localparam logic [1:0] ESC_ORD_RGB = 2'h0;
	localparam logic [1:0] ESC_ORD_GBR = 2'h1;
	localparam logic [1:0] ESC_ORD_YCC = 2'h2;
	localparam logic [7:0] ESC_SIX_MASK = 8'hFC;
endpackage : esc_pkg

// ---- verilog/esc_link_if.sv ----
// Parallel control port between host and encoder.
// Assumes both ends run on core_clk; the data wire is resolved here.
`timescale 1ns/1ps
interface esc_link_if;
	// Control lines from the host
	logic [1:0] host_addr_lines;
	logic rd_wr; // High read, low write
	logic cs_n;
	// Data bus drivers
	logic [7:0] host_dout;
	logic host_oe;
	logic [7:0] dev_dout;
	logic dev_oe;
	// Resolved bus level
	logic [7:0] host_data_bus;
	assign host_data_bus = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hFF);
	modport host (output host_addr_lines, rd_wr, cs_n, host_dout, host_oe,
		input host_data_bus);
	modport dev (input host_addr_lines, rd_wr, cs_n, host_data_bus,
		output dev_dout, dev_oe);
endinterface : esc_link_if

// ---- verilog/esc_dev.sv ----
// Encoder register group: ident, subcarrier, test, mask, luma, lookup.
// Assumes host accesses last one cycle of cs_n low, synchronous to core_clk.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module esc_dev #(
	parameter int LUT_DEPTH = 256
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control port
	esc_link_if.dev link,
	// Timing generator status
	input wire logic combined_sync_event,
	input wire logic [2:0] field_in,
	input wire logic [4:0] line_kind_code,
	input wire logic [7:0] luma_in,
	// Test path
	input wire logic test_upper,
	input wire logic [15:0] test_word_in,
	output logic [15:0] test_word_out,
	// Pixel path
	input wire logic [7:0] pixel_input_port,
	input wire logic color_index_mode,
	output logic [23:0] lut_rgb,
	output logic pixel_rate_clock,
	// Subcarrier settings
	output logic [31:0] subcarrier_step,
	output logic [15:0] active_phase,
	output logic [15:0] burst_phase
);
	import esc_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (LUT_DEPTH != ESC_LUT_DEPTH)
		$error("esc_dev: table depth must match 8-bit index");

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ptr; // Register pointer
		logic [31:0] step; // Subcarrier step word
		logic [15:0] aph; // Active video phase
		logic [15:0] bph; // Burst phase
		logic [7:0] mask; // Index mask
		logic [2:0] field; // Field identification
		logic [4:0] kind; // Line kind
		logic [15:0] tword; // Test word
		logic [7:0] laddr; // Table address
		logic [1:0] lpos; // Byte position in entry
		logic [15:0] lstage; // First two bytes of entry
		logic [7:0] rdata; // Read data to host
		logic oe; // Drive data bus
		logic [3:0] scnt; // Cycles since sync
		logic pix_en; // Pixel rate enable
		logic [23:0] rgb; // Table output
	} esc_dev_st_t;

	localparam esc_dev_st_t ESC_DEV_RST = '0;

	esc_dev_st_t st_q; // Registered state
	esc_dev_st_t st_d; // Next state
	logic [23:0] lut_mem [LUT_DEPTH]; // Tables D, E, F side by side
	logic lut_we; // Table write enable
	logic [23:0] lut_wd; // Table write word
	logic [23:0] lut_hrd; // Entry at host address
	logic [23:0] lut_prd; // Entry at pixel index
	logic [7:0] pix_idx; // Masked pixel index

	// ------------------------------------------------------------
	// Byte select within a table entry, table D first
	// ------------------------------------------------------------
	function automatic logic [7:0] esc_entry_byte(input logic [23:0] e,
		input logic [1:0] pos);
		logic [7:0] b;
		b = e[7:0];
		case (pos)
			2'h0: b = e[23:16];
			2'h1: b = e[15:8];
			default: b = e[7:0];
		endcase
		return b;
	endfunction : esc_entry_byte

	// Index reaches the tables masked in colour index mode
	assign pix_idx = color_index_mode ? (pixel_input_port & st_q.mask) : pixel_input_port; // RL8
	assign lut_hrd = lut_mem[st_q.laddr];
	assign lut_prd = lut_mem[pix_idx];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		lut_we = 1'b0;
		lut_wd = {st_q.lstage, link.host_data_bus};
		st_d.oe = 1'b0;
		// Pixel clock is every second double-rate clock
		st_d.pix_en = ~st_q.pix_en; // RL18
		// Parallel lookup into all three tables
		if (st_q.pix_en)
		begin
			st_d.rgb = lut_prd; // RL13
		end
		// Sync delay counter
		if (combined_sync_event)
		begin
			st_d.scnt = 4'h1;
		end
		else if (st_q.scnt != 4'h0)
		begin
			st_d.scnt = (st_q.scnt == ESC_FIELD_DLY) ? 4'h0 : st_q.scnt + 4'h1;
		end
		// Line kind refresh
		if (st_q.scnt == ESC_KIND_DLY)
		begin
			st_d.kind = line_kind_code; // RL2
		end
		// Field refresh
		if (st_q.scnt == ESC_FIELD_DLY)
		begin
			st_d.field = field_in; // RL1
		end
		// Host access
		if (!link.cs_n)
		begin
			case (link.host_addr_lines)
				ESC_A_PTR:
				begin
					// Pointer load, also the way out of test mode
					if (link.rd_wr)
					begin
						st_d.rdata = st_q.ptr;
						st_d.oe = 1'b1;
					end
					else
					begin
						st_d.ptr = link.host_data_bus;
					end
				end
				ESC_A_REG:
				begin
					if (link.rd_wr)
					begin
						st_d.oe = 1'b1;
						case (st_q.ptr)
							ESC_R_IDENT: st_d.rdata = {st_q.field, st_q.kind}; // RL1 RL2
							ESC_R_STEP0: st_d.rdata = st_q.step[7:0];
							ESC_R_STEP1: st_d.rdata = st_q.step[15:8];
							ESC_R_STEP2: st_d.rdata = st_q.step[23:16];
							ESC_R_STEP3: st_d.rdata = st_q.step[31:24];
							ESC_R_APH_LO: st_d.rdata = st_q.aph[7:0];
							ESC_R_APH_HI: st_d.rdata = st_q.aph[15:8];
							ESC_R_BPH_LO: st_d.rdata = st_q.bph[7:0];
							ESC_R_BPH_HI: st_d.rdata = st_q.bph[15:8];
							ESC_R_TEST: st_d.rdata = test_upper ? test_word_in[15:8] : test_word_in[7:0]; // RL6
							ESC_R_LUMA: st_d.rdata = luma_in; // RL10
							default: st_d.rdata = 8'h00; // Mask and unmapped read zero, RL9
						endcase
					end
					else
					begin
						case (st_q.ptr)
							ESC_R_STEP0: st_d.step[7:0] = link.host_data_bus; // RL3
							ESC_R_STEP1: st_d.step[15:8] = link.host_data_bus; // RL3
							ESC_R_STEP2: st_d.step[23:16] = link.host_data_bus; // RL3
							ESC_R_STEP3: st_d.step[31:24] = link.host_data_bus; // RL3
							ESC_R_APH_LO: st_d.aph[7:0] = link.host_data_bus; // RL4
							ESC_R_APH_HI: st_d.aph[15:8] = link.host_data_bus; // RL4
							ESC_R_BPH_LO: st_d.bph[7:0] = link.host_data_bus; // RL5
							ESC_R_BPH_HI: st_d.bph[15:8] = link.host_data_bus; // RL5
							ESC_R_MASK: st_d.mask = link.host_data_bus; // RL9
							ESC_R_TEST:
							begin
								// Lane chosen by test control
								if (test_upper)
								begin
									st_d.tword[15:8] = link.host_data_bus; // RL6
								end
								else
								begin
									st_d.tword[7:0] = link.host_data_bus; // RL6
								end
							end
							default: st_d.tword = st_q.tword; // Read-only or unmapped
						endcase
					end
					// Test port holds the pointer still
					if (st_q.ptr != ESC_R_TEST)
					begin
						st_d.ptr = st_q.ptr + 8'h01; // RL6
					end
				end
				ESC_A_LADDR:
				begin
					if (link.rd_wr)
					begin
						st_d.rdata = st_q.laddr;
						st_d.oe = 1'b1;
					end
					else
					begin
						st_d.laddr = link.host_data_bus;
						st_d.lpos = 2'h0; // RL19
					end
				end
				default:
				begin
					// Table data, three bytes per entry in D, E, F order
					if (link.rd_wr)
					begin
						st_d.rdata = esc_entry_byte(lut_hrd, st_q.lpos); // RL11
						st_d.oe = 1'b1;
					end
					else if (st_q.lpos == 2'h0)
					begin
						st_d.lstage[15:8] = link.host_data_bus; // RL11
					end
					else if (st_q.lpos == 2'h1)
					begin
						st_d.lstage[7:0] = link.host_data_bus; // RL11
					end
					else
					begin
						lut_we = 1'b1; // RL11
					end
					// Advance address after the third byte
					if (st_q.lpos == 2'h2)
					begin
						st_d.lpos = 2'h0;
						st_d.laddr = st_q.laddr + 8'h01; // RL12
					end
					else
					begin
						st_d.lpos = st_q.lpos + 2'h1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st_q <= ESC_DEV_RST;
		else
			st_q <= st_d;
	end

	// ------------------------------------------------------------
	// Table memory write
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (lut_we)
			lut_mem[st_q.laddr] <= lut_wd; // RL12
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.dev_dout = st_q.rdata;
	assign link.dev_oe = st_q.oe;
	assign test_word_out = st_q.tword;
	assign lut_rgb = st_q.rgb; // RL13
	assign pixel_rate_clock = st_q.pix_en;
	assign subcarrier_step = st_q.step; // RL3
	assign active_phase = st_q.aph; // RL4
	assign burst_phase = st_q.bph; // RL5
endmodule : esc_dev

// ---- verilog/esc_host.sv ----
// Host end: turns command register writes into control port cycles.
// Assumes the encoder answers a read in the cycle after cs_n low.
`timescale 1ns/1ps
module esc_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Command port
	input wire logic [3:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [7:0] cmd_rdata,
	// Control port
	esc_link_if.host link
);
	import esc_pkg::*;

	typedef enum {ESC_IDLE, ESC_STROBE, ESC_CAP} esc_hst_t;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] lines; // Lines for single access
		logic [3:0] cfg; // Order, six-bit, unity
		logic [23:0] comp; // Three component bytes
		logic [39:0] q; // Up to four queued accesses
		logic [2:0] left; // Accesses still queued
		logic is_rd; // Queue is one read
		logic [1:0] q_a; // Current lines
		logic [7:0] q_d; // Current data
		logic cs_n; // Chip select
		logic rd_wr; // Direction
		logic oe; // Drive data
		logic [7:0] last; // Last byte read
		logic [7:0] rdata; // Command read data
		esc_hst_t fsm; // Link sequencer
	} esc_host_st_t;

	esc_host_st_t st_q; // Registered state
	esc_host_st_t st_d; // Next state

	// Component for load slot, by table order and format
	function automatic logic [7:0] esc_slot(input logic [3:0] cfg,
		input logic [23:0] comp, input logic [7:0] addr, input logic [1:0] s);
		logic [1:0] k;
		logic [7:0] b;
		k = s;
		if (cfg[1:0] == ESC_ORD_GBR)
			k = (s == 2'h2) ? 2'h0 : s + 2'h1; // RL16
		case (k)
			2'h0: b = comp[23:16]; // Red or luma, RL17
			2'h1: b = comp[15:8];
			default: b = comp[7:0];
		endcase
		if (cfg[3])
			b = addr; // RL15
		if (cfg[2])
			b = b & ESC_SIX_MASK; // RL14
		return b;
	endfunction : esc_slot

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		// Command reads answer next cycle
		if (cmd_rd)
		begin
			case (cmd_addr)
				ESC_H_LINES: st_d.rdata = {6'h00, st_q.lines};
				ESC_H_READ: st_d.rdata = st_q.last;
				ESC_H_STAT: st_d.rdata = {7'h00, st_q.left != 3'h0};
				ESC_H_LCFG: st_d.rdata = {4'h0, st_q.cfg};
				default: st_d.rdata = 8'h00;
			endcase
		end
		// Command writes; starts ignored while busy
		if (cmd_wr)
		begin
			case (cmd_addr)
				ESC_H_LINES: st_d.lines = cmd_wdata[1:0];
				ESC_H_LCFG: st_d.cfg = cmd_wdata[3:0];
				ESC_H_COMP0: st_d.comp[23:16] = cmd_wdata;
				ESC_H_COMP1: st_d.comp[15:8] = cmd_wdata;
				ESC_H_COMP2: st_d.comp[7:0] = cmd_wdata;
				default: st_d.lines = st_q.lines;
			endcase
			if (st_q.left == 3'h0)
			begin
				case (cmd_addr)
					ESC_H_WRITE:
					begin
						st_d.q[39:30] = {st_q.lines, cmd_wdata};
						st_d.left = 3'h1;
						st_d.is_rd = 1'b0;
					end
					ESC_H_READ:
					begin
						st_d.q[39:30] = {st_q.lines, 8'h00};
						st_d.left = 3'h1;
						st_d.is_rd = 1'b1;
					end
					ESC_H_EXIT:
					begin
						st_d.q[39:30] = {ESC_A_PTR, 8'h00}; // RL7
						st_d.left = 3'h1;
						st_d.is_rd = 1'b0;
					end
					ESC_H_LGO:
					begin
						// Address, then three bytes in table order
						st_d.q = {ESC_A_LADDR, cmd_wdata,
							ESC_A_LDATA, esc_slot(st_q.cfg, st_q.comp, cmd_wdata, 2'h0),
							ESC_A_LDATA, esc_slot(st_q.cfg, st_q.comp, cmd_wdata, 2'h1),
							ESC_A_LDATA, esc_slot(st_q.cfg, st_q.comp, cmd_wdata, 2'h2)}; // RL11
						st_d.left = 3'h4;
						st_d.is_rd = 1'b0;
					end
					default: st_d.is_rd = st_q.is_rd;
				endcase
			end
		end
		// Link sequencer
		case (st_q.fsm)
			ESC_IDLE:
			begin
				if (st_q.left != 3'h0)
				begin
					st_d.cs_n = 1'b0;
					st_d.rd_wr = st_q.is_rd;
					st_d.oe = ~st_q.is_rd;
					{st_d.q_a, st_d.q_d} = st_q.q[39:30];
					st_d.fsm = ESC_STROBE;
				end
			end
			ESC_STROBE:
			begin
				st_d.cs_n = 1'b1;
				st_d.oe = 1'b0;
				st_d.rd_wr = 1'b1;
				st_d.fsm = ESC_CAP;
			end
			default:
			begin
				if (st_q.is_rd)
					st_d.last = link.host_data_bus;
				st_d.q = {st_q.q[29:0], 10'h000};
				st_d.left = st_q.left - 3'h1;
				st_d.fsm = ESC_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.cs_n <= 1'b1;
			st_q.rd_wr <= 1'b1;
			st_q.fsm <= ESC_IDLE;
		end
		else
			st_q <= st_d;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cmd_rdata = st_q.rdata;
	assign link.host_addr_lines = st_q.q_a;
	assign link.rd_wr = st_q.rd_wr;
	assign link.cs_n = st_q.cs_n;
	assign link.host_dout = st_q.q_d;
	assign link.host_oe = st_q.oe;
endmodule : esc_host

// ---- testbench/esc_link_checker.sv ----
// Checker for the encoder control port, watching the link signals only.
// Assumes one clock, core_clk, and a synchronous active-low reset.
`timescale 1ns/1ps
module esc_link_checker
	import esc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link lines
	input wire logic [1:0] host_addr_lines,
	input wire logic rd_wr,
	input wire logic cs_n,
	input wire logic [7:0] host_dout,
	input wire logic host_oe,
	input wire logic [7:0] dev_dout,
	input wire logic dev_oe,
	input wire logic [7:0] host_data_bus
);
	// ------------------------------------------------------------
	// Shadow of device pointer and table address
	// ------------------------------------------------------------
	logic [7:0] ptr_q; // Register pointer as the device should hold it
	logic [7:0] laddr_q; // Table address as the device should hold it
	logic [1:0] pos_q; // Byte position within a table entry
	// Follow every taken access
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ptr_q <= 8'h00;
			laddr_q <= 8'h00;
			pos_q <= 2'h0;
		end
		else if (!cs_n)
		begin
			if (host_addr_lines == ESC_A_PTR && !rd_wr)
				ptr_q <= host_data_bus;
			if (host_addr_lines == ESC_A_REG && ptr_q != ESC_R_TEST)
				ptr_q <= ptr_q + 8'h01;
			if (host_addr_lines == ESC_A_LADDR && !rd_wr)
			begin
				laddr_q <= host_data_bus;
				pos_q <= 2'h0;
			end
			if (host_addr_lines == ESC_A_LDATA)
			begin
				pos_q <= (pos_q == 2'h2) ? 2'h0 : pos_q + 2'h1;
				if (pos_q == 2'h2)
					laddr_q <= laddr_q + 8'h01;
			end
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence rd_req;
		!cs_n && rd_wr;
	endsequence
	sequence wr_req;
		!cs_n && !rd_wr;
	endsequence
	sequence answer;
		dev_oe ##1 !dev_oe;
	endsequence
	read_answer_a: assert property (rd_req |=> answer)
		else $error("read not answered for exactly one cycle");
	write_quiet_a: assert property (wr_req |=> !dev_oe)
		else $error("device drove bus after a write");
	oe_cause_a: assert property ($rose(dev_oe) |-> !$past(cs_n) && $past(rd_wr))
		else $error("device drove bus without a read");
	no_fight_a: assert property (!(dev_oe && host_oe))
		else $error("both ends drive the bus");
	host_drive_a: assert property (host_oe |-> !cs_n && !rd_wr && host_data_bus == host_dout)
		else $error("host drives bus outside a write");
	cs_pulse_a: assert property ($fell(cs_n) |=> cs_n [*2])
		else $error("select not a spaced single pulse");
	ptr_read_a: assert property (rd_req and host_addr_lines == ESC_A_PTR |=> dev_dout == ptr_q)
		else $error("pointer read back wrong");
	mask_read_a: assert property (rd_req and host_addr_lines == ESC_A_REG
		and ptr_q == ESC_R_MASK |=> dev_dout == 8'h00)
		else $error("mask register read back data");
	laddr_read_a: assert property (rd_req and host_addr_lines == ESC_A_LADDR
		|=> dev_dout == laddr_q)
		else $error("table address not advanced as expected");
endmodule : esc_link_checker

// ---- testbench/esc_tb.sv ----
// Testbench: host command port and device status inputs driven, both ends joined.
// Assumes the design package and the link interface are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module esc_tb;
	import esc_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] cmd_addr = 4'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [7:0] cmd_rdata;
	logic combined_sync_event = 1'b0;
	logic [2:0] field_in = 3'h0;
	logic [4:0] line_kind_code = 5'h00;
	logic [7:0] luma_in = 8'h00;
	logic test_upper = 1'b0;
	logic [15:0] test_word_in = 16'h0000;
	logic [7:0] pixel_input_port = 8'h00;
	logic color_index_mode = 1'b0;
	logic [15:0] test_word_out, active_phase, burst_phase;
	logic [23:0] lut_rgb;
	logic [31:0] subcarrier_step;
	logic pixel_rate_clock;
	logic [7:0] rd_d; // Last byte read over the link
	int err_count = 0;
	int compares = 0;
	esc_link_if esc_link_if_i ();
	esc_dev esc_dev_i (.core_clk(core_clk), .rst_n(rst_n), .link(esc_link_if_i),
		.combined_sync_event(combined_sync_event), .field_in(field_in),
		.line_kind_code(line_kind_code), .luma_in(luma_in), .test_upper(test_upper),
		.test_word_in(test_word_in), .test_word_out(test_word_out),
		.pixel_input_port(pixel_input_port), .color_index_mode(color_index_mode),
		.lut_rgb(lut_rgb), .pixel_rate_clock(pixel_rate_clock),
		.subcarrier_step(subcarrier_step), .active_phase(active_phase),
		.burst_phase(burst_phase));
	esc_host esc_host_i (.core_clk(core_clk), .rst_n(rst_n), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
		.link(esc_link_if_i));
	esc_link_checker esc_link_checker_i (.core_clk(core_clk), .rst_n(rst_n),
		.host_addr_lines(esc_link_if_i.host_addr_lines), .rd_wr(esc_link_if_i.rd_wr),
		.cs_n(esc_link_if_i.cs_n), .host_dout(esc_link_if_i.host_dout),
		.host_oe(esc_link_if_i.host_oe), .dev_dout(esc_link_if_i.dev_dout),
		.dev_oe(esc_link_if_i.dev_oe), .host_data_bus(esc_link_if_i.host_data_bus));
	// 50 MHz clock
	always #10 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// Command port and link tasks
	// ------------------------------------------------------------
	task automatic cw(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
	endtask : cw
	task automatic cr(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge core_clk);
		cmd_rd <= 1'b0;
		@(negedge core_clk);
		d = cmd_rdata;
		// Return on a rising edge so callers drive inputs there
		@(posedge core_clk);
	endtask : cr
	// Poll busy under a bounded count
	task automatic idle();
		logic [7:0] s;
		int n;
		s = 8'h01;
		n = 0;
		while (s[0] !== 1'b0 && n < 30)
		begin
			cr(ESC_H_STAT, s);
			n++;
		end
		if (n >= 30)
			`CHK(s[0], 1'b0)
	endtask : idle
	task automatic lw(input logic [1:0] a, input logic [7:0] d);
		cw(ESC_H_LINES, {6'h00, a});
		cw(ESC_H_WRITE, d);
		idle();
	endtask : lw
	task automatic lr(input logic [1:0] a, output logic [7:0] d);
		cw(ESC_H_LINES, {6'h00, a});
		cw(ESC_H_READ, 8'h00);
		idle();
		cr(ESC_H_READ, d);
	endtask : lr
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_subcarrier();
		lw(ESC_A_PTR, ESC_R_STEP0);
		for (int i = 0; i < 8; i++)
			lw(ESC_A_REG, 8'h11 * (8'(i) + 8'h01));
		`CHK(subcarrier_step, 32'h44332211)
		`CHK(active_phase, 16'h6655)
		`CHK(burst_phase, 16'h8877)
		lw(ESC_A_PTR, ESC_R_STEP3);
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d, 8'h44)
		$display("test subcarrier done");
	endtask : t_subcarrier
	task automatic t_ident();
		// Wanted values stand only in the cycle before their load edge
		field_in <= 3'h2;
		line_kind_code <= 5'h09;
		@(posedge core_clk);
		combined_sync_event <= 1'b1;
		@(posedge core_clk);
		combined_sync_event <= 1'b0;
		repeat (4) @(posedge core_clk);
		line_kind_code <= 5'h16;
		@(posedge core_clk);
		line_kind_code <= 5'h09;
		repeat (6) @(posedge core_clk);
		field_in <= 3'h5;
		@(posedge core_clk);
		field_in <= 3'h2;
		lw(ESC_A_PTR, ESC_R_IDENT);
		lw(ESC_A_REG, 8'h00);
		lw(ESC_A_PTR, ESC_R_IDENT);
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d[7:5], 3'h5)
		`CHK(rd_d[4:0], 5'h16)
		$display("test ident done");
	endtask : t_ident
	task automatic t_mask_luma();
		lw(ESC_A_PTR, ESC_R_MASK);
		lw(ESC_A_REG, 8'h0F);
		lw(ESC_A_PTR, ESC_R_MASK);
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d, 8'h00)
		luma_in <= 8'hA5;
		lw(ESC_A_PTR, ESC_R_LUMA);
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d, 8'hA5)
		$display("test mask luma done");
	endtask : t_mask_luma
	task automatic t_test_port();
		test_upper <= 1'b1;
		test_word_in <= 16'h1234;
		lw(ESC_A_PTR, ESC_R_TEST);
		lr(ESC_A_REG, rd_d);
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d, 8'h12)
		test_upper <= 1'b0;
		lr(ESC_A_REG, rd_d);
		`CHK(rd_d, 8'h34)
		lw(ESC_A_REG, 8'hAB);
		`CHK(test_word_out, 16'h00AB)
		lr(ESC_A_PTR, rd_d);
		`CHK(rd_d, ESC_R_TEST)
		cw(ESC_H_EXIT, 8'h00);
		idle();
		lr(ESC_A_PTR, rd_d);
		`CHK(rd_d, 8'h00)
		$display("test port done");
	endtask : t_test_port
	// Load one entry through the host and look it up by pixel
	task automatic host_load(input logic [7:0] cfg, input logic [23:0] c,
		input logic [7:0] a, input logic [23:0] exp);
		cw(ESC_H_LCFG, cfg);
		cw(ESC_H_COMP0, c[23:16]);
		cw(ESC_H_COMP1, c[15:8]);
		cw(ESC_H_COMP2, c[7:0]);
		cw(ESC_H_LGO, a);
		idle();
		pixel_input_port <= 8'hF0 | a;
		repeat (6) @(negedge core_clk);
		`CHK(lut_rgb, exp)
	endtask : host_load
	task automatic t_lut();
		lw(ESC_A_LADDR, 8'h05);
		lw(ESC_A_LDATA, 8'h99);
		lw(ESC_A_LADDR, 8'h05);
		for (int i = 1; i < 4; i++)
			lw(ESC_A_LDATA, 8'h11 * 8'(i));
		lr(ESC_A_LADDR, rd_d);
		`CHK(rd_d, 8'h06)
		lw(ESC_A_LADDR, 8'h05);
		for (int i = 1; i < 4; i++)
		begin
			lr(ESC_A_LDATA, rd_d);
			`CHK(rd_d, 8'h11 * 8'(i))
		end
		lr(ESC_A_LADDR, rd_d);
		`CHK(rd_d, 8'h06)
		lw(ESC_A_PTR, ESC_R_MASK);
		lw(ESC_A_REG, 8'h0F);
		color_index_mode <= 1'b1;
		pixel_input_port <= 8'hF5;
		repeat (6) @(negedge core_clk);
		`CHK(lut_rgb, 24'h112233)
		host_load({6'h00, ESC_ORD_RGB}, 24'h405060, 8'h07, 24'h405060);
		host_load({6'h00, ESC_ORD_GBR}, 24'h415161, 8'h07, 24'h516141);
		host_load({6'h00, ESC_ORD_YCC}, 24'h425262, 8'h07, 24'h425262);
		host_load(8'h04, 24'hFFFFFF, 8'h08, 24'hFCFCFC);
		host_load(8'h08, 24'h000000, 8'h09, 24'h090909);
		// Pixel enable flips on every double-rate clock
		@(negedge core_clk);
		rd_d[0] = pixel_rate_clock;
		@(negedge core_clk);
		`CHK(pixel_rate_clock, ~rd_d[0])
		$display("test lookup done");
	endtask : t_lut
	// ------------------------------------------------------------
	// Verdict, main sequence and watchdog
	// ------------------------------------------------------------
	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		t_subcarrier();
		t_ident();
		t_mask_luma();
		t_test_port();
		t_lut();
		test_done();
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("watchdog expired");
		test_done();
	end
endmodule : esc_tb
